// *** core/gqs_select.sv ***
// Qualification select registers on AXI4-Lite with 48 per-pin input paths
`timescale 1ns/1ps
module gqs_select
  import gqs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [GQS_NUM_PINS-1:0] pin_in,
  output logic [GQS_NUM_PINS-1:0] gpio_in_data,
  output logic [GQS_NUM_PINS-1:0] periph_in_data
);

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_param
    $error("gqs_select: address width must be 8 to 32 bits");
  end

  logic [31:0] port_a_high_qual_select;
  logic [31:0] port_b_low_qual_select;
  logic [31:0] port_b_high_qual_select;
  logic [31:0] port_a_qual_control;
  logic [31:0] port_b_qual_control;
  logic protected_write_unlock;

  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;

  // Index of the register at a byte address; misaligned or out-of-range addresses miss
  function automatic logic [3:0] gqs_decode(input logic [ADDR_W-1:0] addr);
    logic [7:0] low;
    logic hit_range;
    low = addr[7:0];
    hit_range = ((addr >> 8) == '0) && (low[1:0] == 2'h0);
    if (!hit_range) begin
      return 4'h8;
    end
    case (low)
      GQS_OFF_A_HIGH_SEL: return {1'b0, GQS_R_A_HIGH_SEL};
      GQS_OFF_B_LOW_SEL: return {1'b0, GQS_R_B_LOW_SEL};
      GQS_OFF_B_HIGH_SEL: return {1'b0, GQS_R_B_HIGH_SEL};
      GQS_OFF_A_CTRL: return {1'b0, GQS_R_A_CTRL};
      GQS_OFF_B_CTRL: return {1'b0, GQS_R_B_CTRL};
      GQS_OFF_UNLOCK: return {1'b0, GQS_R_UNLOCK};
      GQS_OFF_LEVEL_LO: return {1'b0, GQS_R_LEVEL_LO};
      GQS_OFF_LEVEL_HI: return {1'b0, GQS_R_LEVEL_HI};
      default: return 4'h8;
    endcase
  endfunction

  // Write channel: address and data are caught independently, the write lands once both are held
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_do = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] wr_idx = gqs_decode(aw_addr_q);
  wire wr_mapped = !wr_idx[3];
  // Protected registers silently keep their value while locked; the bus still answers OKAY
  wire wr_prot_ok = wr_do && protected_write_unlock;
  wire wr_a_high = wr_prot_ok && wr_idx == {1'b0, GQS_R_A_HIGH_SEL};
  wire wr_b_low = wr_prot_ok && wr_idx == {1'b0, GQS_R_B_LOW_SEL};
  wire wr_b_high = wr_prot_ok && wr_idx == {1'b0, GQS_R_B_HIGH_SEL};
  wire wr_a_ctrl = wr_prot_ok && wr_idx == {1'b0, GQS_R_A_CTRL};
  wire wr_b_ctrl = wr_prot_ok && wr_idx == {1'b0, GQS_R_B_CTRL};
  wire wr_unlock = wr_do && wr_idx == {1'b0, GQS_R_UNLOCK};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= GQS_RESET_VALUE;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= GQS_RESP_OKAY;
    end else if (aclken) begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? GQS_RESP_OKAY : GQS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reset wins over the clock enable so a frozen block still comes up in sync-only mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_a_high_qual_select <= GQS_RESET_VALUE;
      port_b_low_qual_select <= GQS_RESET_VALUE;
      port_b_high_qual_select <= GQS_RESET_VALUE;
      port_a_qual_control <= GQS_RESET_VALUE;
      port_b_qual_control <= GQS_RESET_VALUE;
      protected_write_unlock <= 1'b0;
    end else if (aclken) begin
      if (wr_a_high) begin
        port_a_high_qual_select <= gqs_merge(port_a_high_qual_select, w_data_q, w_strb_q);
      end
      if (wr_b_low) begin
        port_b_low_qual_select <= gqs_merge(port_b_low_qual_select, w_data_q, w_strb_q);
      end
      if (wr_b_high) begin
        port_b_high_qual_select <= gqs_merge(port_b_high_qual_select, w_data_q, w_strb_q);
      end
      if (wr_a_ctrl) begin
        port_a_qual_control <= gqs_merge(port_a_qual_control, w_data_q, w_strb_q);
      end
      if (wr_b_ctrl) begin
        port_b_qual_control <= gqs_merge(port_b_qual_control, w_data_q, w_strb_q);
      end
      if (wr_unlock && w_strb_q[0]) begin
        protected_write_unlock <= w_data_q[GQS_UNLOCK_BIT];
      end
    end
  end

  // Pin fabric: pin 16+i takes code bits 2i+1:2i and the period byte of its group of eight
  wire [95:0] code_flat = {port_b_high_qual_select, port_b_low_qual_select, port_a_high_qual_select};
  wire [63:0] period_flat = {port_b_qual_control, port_a_qual_control};
  logic [1:0] pin_code [GQS_NUM_PINS];
  logic [GQS_PERIOD_W-1:0] pin_period [GQS_NUM_PINS];

  for (genvar i = 0; i < GQS_NUM_PINS; i++) begin : g_pin
    assign pin_code[i] = code_flat[2*i+:2];
    assign pin_period[i] = period_flat[GQS_PERIOD_W*((i+GQS_FIRST_PIN)/8)+:GQS_PERIOD_W];

    gqs_qualifier #(
      .HIST_W(GQS_SAMPLES_SIX),
      .PERIOD_W(GQS_PERIOD_W)
    ) u_qual (
      .aclk(aclk),
      .aresetn(aresetn),
      .aclken(aclken),
      .pin(pin_in[i]),
      .code(pin_code[i]),
      .period(pin_period[i]),
      .qual_level(gpio_in_data[i])
    );

    // Asynchronous choice bypasses every flop; only the peripheral side may see it
    assign periph_in_data[i] = (pin_code[i] == GQS_CODE_ASYNC) ? pin_in[i] : gpio_in_data[i];
  end

  // Read channel: one read in flight, data registered at acceptance
  assign s_axi_arready = !s_axi_rvalid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [3:0] rd_idx = gqs_decode(s_axi_araddr);
  wire [31:0] level_lo = gpio_in_data[31:0];
  wire [31:0] level_hi = {16'h0000, gpio_in_data[GQS_NUM_PINS-1:32]};
  wire [31:0] rd_word =
    (rd_idx == {1'b0, GQS_R_A_HIGH_SEL}) ? port_a_high_qual_select :
    (rd_idx == {1'b0, GQS_R_B_LOW_SEL}) ? port_b_low_qual_select :
    (rd_idx == {1'b0, GQS_R_B_HIGH_SEL}) ? port_b_high_qual_select :
    (rd_idx == {1'b0, GQS_R_A_CTRL}) ? port_a_qual_control :
    (rd_idx == {1'b0, GQS_R_B_CTRL}) ? port_b_qual_control :
    (rd_idx == {1'b0, GQS_R_UNLOCK}) ? {31'h0000_0000, protected_write_unlock} :
    (rd_idx == {1'b0, GQS_R_LEVEL_LO}) ? level_lo :
    (rd_idx == {1'b0, GQS_R_LEVEL_HI}) ? level_hi : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= GQS_RESET_VALUE;
      s_axi_rresp <= GQS_RESP_OKAY;
    end else if (aclken) begin
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_idx[3] ? GQS_RESP_SLVERR : GQS_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking gqs_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  unlock_gate_a: assert property (
    aclken && wr_do && !protected_write_unlock
    |=> $stable(port_a_high_qual_select) && $stable(port_b_low_qual_select) && $stable(port_b_high_qual_select))
    else $error("select register changed while write unlock was clear");

  reset_zero_a: assert property (disable iff (1'b0)
    !aresetn |=> code_flat == 96'h0 && !protected_write_unlock)
    else $error("select codes not zero after reset");

  periph_async_a: assert property (
    pin_code[5] == GQS_CODE_ASYNC |-> periph_in_data[5] == pin_in[5])
    else $error("asynchronous peripheral path not transparent");

  code_map_a: assert property (
    pin_code[32] == port_b_high_qual_select[1:0] && pin_code[47] == port_b_high_qual_select[31:30]
    && pin_code[0] == port_a_high_qual_select[1:0] && pin_code[16] == port_b_low_qual_select[1:0])
    else $error("pin code taken from the wrong register field");

  period_map_a: assert property (
    pin_period[40] == port_b_qual_control[31:24] && pin_period[16] == port_b_qual_control[7:0]
    && pin_period[0] == port_a_qual_control[23:16])
    else $error("pin period taken from the wrong control field");

  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");

  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");

  locked_write_c: cover property (aclken && wr_do && !protected_write_unlock && wr_idx == 4'h0);
  unlocked_write_c: cover property (aclken && wr_a_high);
  async_pin_c: cover property (pin_code[47] == GQS_CODE_ASYNC && pin_in[47]);
  unmapped_read_c: cover property (ar_fire && rd_idx[3]);

endmodule

// *** core/gqs_pkg.sv ***
// Package of constants for the pin input qualification select block
package gqs_pkg;

  localparam int GQS_DATA_W = 32;
  localparam int GQS_NUM_PINS = 48;
  localparam int GQS_FIRST_PIN = 16;
  localparam int GQS_PERIOD_W = 8;
  localparam int GQS_SAMPLES_THREE = 3;
  localparam int GQS_SAMPLES_SIX = 6;
  localparam int GQS_CLK_PERIOD_NS = 4;

  localparam logic [1:0] GQS_CODE_SYNC = 2'h0;
  localparam logic [1:0] GQS_CODE_Q3 = 2'h1;
  localparam logic [1:0] GQS_CODE_Q6 = 2'h2;
  localparam logic [1:0] GQS_CODE_ASYNC = 2'h3;

  localparam logic [7:0] GQS_OFF_A_HIGH_SEL = 8'h00;
  localparam logic [7:0] GQS_OFF_B_LOW_SEL = 8'h04;
  localparam logic [7:0] GQS_OFF_B_HIGH_SEL = 8'h08;
  localparam logic [7:0] GQS_OFF_A_CTRL = 8'h0c;
  localparam logic [7:0] GQS_OFF_B_CTRL = 8'h10;
  localparam logic [7:0] GQS_OFF_UNLOCK = 8'h14;
  localparam logic [7:0] GQS_OFF_LEVEL_LO = 8'h18;
  localparam logic [7:0] GQS_OFF_LEVEL_HI = 8'h1c;

  localparam logic [2:0] GQS_R_A_HIGH_SEL = 3'h0;
  localparam logic [2:0] GQS_R_B_LOW_SEL = 3'h1;
  localparam logic [2:0] GQS_R_B_HIGH_SEL = 3'h2;
  localparam logic [2:0] GQS_R_A_CTRL = 3'h3;
  localparam logic [2:0] GQS_R_B_CTRL = 3'h4;
  localparam logic [2:0] GQS_R_UNLOCK = 3'h5;
  localparam logic [2:0] GQS_R_LEVEL_LO = 3'h6;
  localparam logic [2:0] GQS_R_LEVEL_HI = 3'h7;

  localparam logic [31:0] GQS_RESET_VALUE = 32'h0000_0000;
  localparam int GQS_UNLOCK_BIT = 0;

  localparam logic [1:0] GQS_RESP_OKAY = 2'h0;
  localparam logic [1:0] GQS_RESP_SLVERR = 2'h2;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] gqs_merge(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b+:8] = data[8*b+:8];
      end
    end
    return res;
  endfunction

endpackage

// *** core/gqs_qualifier.sv ***
// One pin's synchroniser, sample clock divider and three/six sample qualifier
`timescale 1ns/1ps
module gqs_qualifier
  import gqs_pkg::*;
#(
  parameter int HIST_W = GQS_SAMPLES_SIX,
  parameter int PERIOD_W = GQS_PERIOD_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic pin,
  input wire logic [1:0] code,
  input wire logic [PERIOD_W-1:0] period,
  output logic qual_level
);

  if (HIST_W < GQS_SAMPLES_SIX || PERIOD_W < 1) begin : g_bad_param
    $error("gqs_qualifier: history shorter than six samples or empty period field");
  end

  logic sync_first;
  logic sync_second;
  logic [PERIOD_W:0] gap_left;
  logic [HIST_W-1:0] hist;

  // Divider reloads 2n-1 so a tick lands every 2n clocks; period 0 ticks every clock
  wire tick = (gap_left == '0);
  wire [PERIOD_W:0] reload = (period == '0) ? '0 : ({period, 1'b0} - 1'b1);
  wire [HIST_W-1:0] next_hist = tick ? {hist[HIST_W-2:0], sync_second} : hist;
  wire three_high = &next_hist[GQS_SAMPLES_THREE-1:0];
  wire three_low = ~|next_hist[GQS_SAMPLES_THREE-1:0];
  wire six_high = &next_hist[GQS_SAMPLES_SIX-1:0];
  wire six_low = ~|next_hist[GQS_SAMPLES_SIX-1:0];
  wire q3_level = three_high ? 1'b1 : (three_low ? 1'b0 : qual_level);
  wire q6_level = six_high ? 1'b1 : (six_low ? 1'b0 : qual_level);
  // Code 11 on the GPIO side degrades to plain synchronisation
  wire next_level = (code == GQS_CODE_Q3) ? q3_level :
                    (code == GQS_CODE_Q6) ? q6_level : sync_second;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      gap_left <= '0;
      hist <= '0;
      qual_level <= 1'b0;
    end else if (aclken) begin
      sync_first <= pin;
      sync_second <= sync_first;
      gap_left <= tick ? reload : gap_left - 1'b1;
      hist <= next_hist;
      qual_level <= next_level;
    end
  end

  // Helper: enabled clocks since the last tick, and whether the period moved meanwhile
  logic [PERIOD_W:0] gap_seen;
  logic [PERIOD_W-1:0] last_period;
  logic period_dirty;
  wire [PERIOD_W:0] gap_expect = (period == '0) ? (PERIOD_W+1)'(1) : {period, 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_seen <= '0;
      last_period <= '0;
      period_dirty <= 1'b1;
    end else if (aclken) begin
      gap_seen <= tick ? (PERIOD_W+1)'(1) : gap_seen + 1'b1;
      last_period <= period;
      period_dirty <= tick ? 1'b0 : (period_dirty || period != last_period);
    end
  end

  sync_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aclken && code == GQS_CODE_SYNC |=> qual_level == $past(sync_second))
    else $error("sync-only pin did not follow its synchroniser");

  async_gpio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aclken && code == GQS_CODE_ASYNC |=> qual_level == $past(sync_second))
    else $error("code 11 gpio level not synchronised like code 00");

  three_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(code) == GQS_CODE_Q3 && qual_level != $past(qual_level)
    |-> hist[GQS_SAMPLES_THREE-1:0] == {GQS_SAMPLES_THREE{qual_level}})
    else $error("three-sample level changed without three agreeing samples");

  six_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(code) == GQS_CODE_Q6 && qual_level != $past(qual_level)
    |-> hist[GQS_SAMPLES_SIX-1:0] == {GQS_SAMPLES_SIX{qual_level}})
    else $error("six-sample level changed without six agreeing samples");

  sample_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aclken && tick && !period_dirty && period == last_period |-> gap_seen == gap_expect)
    else $error("sample spacing differs from the period field");

endmodule

// *** sim/gqs_pin_model.sv ***
// External pin model: drives commanded pin levels, with optional one-cycle glitches
`timescale 1ns/1ps
module gqs_pin_model
  import gqs_pkg::*;
(
  input wire logic aclk,
  input wire logic [GQS_NUM_PINS-1:0] level,
  input wire logic [GQS_NUM_PINS-1:0] glitch,
  output logic [GQS_NUM_PINS-1:0] pin_in
);
  initial pin_in = '0;
  // Pins move just after an edge, as a board source clocked from the same oscillator would
  always @(posedge aclk) begin
    pin_in <= level ^ glitch;
  end
endmodule

// *** sim/gqs_select_test.sv ***
// Self-checking bench for the qualification select block
`timescale 1ns/1ps
module gqs_select_test
  import gqs_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = '0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [47:0] pin_in, gpio_in_data, periph_in_data, p1, p2, p3, m;
  logic [47:0] lvl = '0;
  logic [47:0] glitch = '0;
  logic [15:0] lfsr_state = 16'ha25a;
  logic [31:0] r, r2, d, ca, cb;
  logic [31:0] w [3];
  logic [1:0] resp, code;
  logic [7:0] sel_off [3] = '{GQS_OFF_A_HIGH_SEL, GQS_OFF_B_LOW_SEL, GQS_OFF_B_HIGH_SEL};
  logic [31:0] corner [3] = '{32'h0000_0003, 32'h0000_0000, 32'hc000_0000};
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  int i, n, p, cnt, lo, hi;

  always #2 aclk = ~aclk;

  gqs_select gqs_select_inst (.aclk(aclk), .aresetn(aresetn), .aclken(1'b1),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pin_in(pin_in), .gpio_in_data(gpio_in_data),
    .periph_in_data(periph_in_data));

  gqs_pin_model gqs_pin_model_inst (.aclk(aclk), .level(lvl), .glitch(glitch), .pin_in(pin_in));

  // Reference delay line: a synchronised path shows the pin three edges late
  always @(posedge aclk) begin
    p1 <= pin_in;
    p2 <= p1;
    p3 <= p2;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic int ival(input int pr);
    return (pr == 0) ? 1 : 2 * pr;
  endfunction

  // Codes limited to 00 and 11 so every pin has an exactly predictable output
  function automatic logic [31:0] spread(input logic [15:0] b);
    logic [31:0] x;
    for (int k = 0; k < 16; k++) x[2*k+:2] = {b[k], b[k]};
    return x;
  endfunction

  function automatic logic [47:0] fwd_mask(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    logic [95:0] all;
    logic [47:0] x;
    all = {c, b, a};
    for (int k = 0; k < 48; k++) x[k] = (all[2*k+:2] == GQS_CODE_ASYNC);
    return x;
  endfunction

  task automatic rnd(output logic [31:0] v);
    lfsr_state = lfsr_next(lfsr_state);
    v[15:0] = lfsr_state;
    lfsr_state = lfsr_next(lfsr_state);
    v[31:16] = lfsr_state;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_write(a, v, rs);
    check(48'(rs), 48'(GQS_RESP_OKAY));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Ceiling sits well above the few thousand cycles the sequence needs
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      axi_read(sel_off[j], d, resp);
      check(48'(d), 48'(GQS_RESET_VALUE));
    end
    wr(GQS_OFF_A_HIGH_SEL, 32'h5555_5555);
    axi_read(GQS_OFF_A_HIGH_SEL, d, resp);
    check(48'(d), 48'h0);
    axi_write(8'h40, 32'h1, resp);
    check(48'(resp), 48'(GQS_RESP_SLVERR));
    axi_read(8'h44, d, resp);
    check(48'(resp), 48'(GQS_RESP_SLVERR));
    check(48'(d), 48'h0);
    wr(GQS_OFF_UNLOCK, 32'h1);
    for (int j = 0; j < 3; j++) begin
      rnd(r);
      wr(sel_off[j], r);
      axi_read(sel_off[j], d, resp);
      check(48'(d), 48'(r));
    end
    // Mixed synchronised and pass-through codes under random pin traffic
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3; j++) begin
        rnd(r);
        w[j] = (k == 0) ? corner[j] : spread(r[15:0]);
        wr(sel_off[j], w[j]);
      end
      m = fwd_mask(w[0], w[1], w[2]);
      repeat (30) begin
        rnd(r);
        rnd(r2);
        lvl <= {r[15:0], r2};
        @(posedge aclk);
        #1;
        check(gpio_in_data, p3);
        check(periph_in_data, (pin_in & m) | (p3 & ~m));
      end
    end
    // One qualified pin per eight-pin group; the other groups get the longest period
    for (int g = 0; g < 6; g++) begin
      rnd(r);
      i = 8 * g + int'(r[2:0]);
      code = r[3] ? GQS_CODE_Q6 : GQS_CODE_Q3;
      n = r[3] ? GQS_SAMPLES_SIX : GQS_SAMPLES_THREE;
      p = int'(r[5:4]);
      lvl <= '0;
      w = '{default: 32'h0};
      w[i / 16][2 * (i % 16)+:2] = code;
      ca = 32'hffff_ffff;
      cb = 32'hffff_ffff;
      if (g < 2) ca[8 * (g + 2)+:8] = 8'(p);
      else cb[8 * (g - 2)+:8] = 8'(p);
      wr(GQS_OFF_A_CTRL, ca);
      wr(GQS_OFF_B_CTRL, cb);
      for (int j = 0; j < 3; j++) wr(sel_off[j], w[j]);
      // A divider still counting down the old 510-clock period only reloads at its next tick
      repeat (520) @(posedge aclk);
      glitch <= 48'h1 << i;
      @(posedge aclk);
      glitch <= '0;
      repeat (60) @(posedge aclk);
      check(48'(gpio_in_data[i]), 48'h0);
      lvl <= 48'h1 << i;
      @(posedge aclk);
      cnt = 0;
      do begin
        @(posedge aclk);
        #1;
        cnt++;
      end while (gpio_in_data[i] !== 1'b1 && cnt < 200);
      lo = 2 + (n - 1) * ival(p);
      hi = 4 + n * ival(p);
      check(48'(cnt >= lo && cnt <= hi), 48'h1);
      check(48'(periph_in_data[i]), 48'h1);
      axi_read(GQS_OFF_LEVEL_LO, d, resp);
      axi_read(GQS_OFF_LEVEL_HI, r2, resp);
      check({r2[15:0], d}, 48'h1 << i);
    end
    // Reset in mid-run must clear codes that were written before it
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      axi_read(sel_off[j], d, resp);
      check(48'(d), 48'(GQS_RESET_VALUE));
    end
    give_verdict();
  end
endmodule
